/* src/line_status_monitor_regs.sv */
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
module line_status_monitor_regs
   import line_mon_pkg::*;
(
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic [ADDR_W-1:0]          avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic      [31:0]                avs_readdata,
   output logic                            avs_waitrequest,
   input  wire logic                       rxOverloadPin,
   input  wire logic                       offHookSettlingPin,
   input  wire logic                       loopCurrentPin,
   input  wire logic                       offHookPin,
   input  wire logic                       lineSideEnablePin,
   input  wire logic                       overcurrent160Pin,
   input  wire logic                       overcurrent60Pin,
   input  wire logic signed [SAMPLE_W-1:0] rxSample,
   input  wire logic signed [SAMPLE_W-1:0] txSample,
   output logic signed      [SAMPLE_W-1:0] monitorRxOut,
   output logic signed      [SAMPLE_W-1:0] monitorTxOut,
   output logic signed      [SAMPLE_W:0]   monitorOutput,
   output logic                            irq
);
   localparam int NSYNC        = 7;
   localparam int SYNC_STAGES  = 2;
   // positions of the pins in the synchroniser word
   localparam int PIN_OVERLOAD = 6;
   localparam int PIN_SETTLING = 5;
   localparam int PIN_LOOP     = 4;
   localparam int PIN_OFF_HOOK = 3;
   localparam int PIN_LINE_EN  = 2;
   localparam int PIN_OC160    = 1;
   localparam int PIN_OC60     = 0;

   // pin synchronisers: first stage read only by second stage
   logic [NSYNC-1:0] syncA_r;
   logic [NSYNC-1:0] syncB_r;
   wire  [NSYNC-1:0] pinsRaw = {rxOverloadPin, offHookSettlingPin, loopCurrentPin,
                                offHookPin, lineSideEnablePin, overcurrent160Pin,
                                overcurrent60Pin};

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syncA_r <= '0;
         syncB_r <= '0;
      end
      else
      begin
         syncA_r <= pinsRaw;
         syncB_r <= syncA_r;
      end
   end

   // the synchronisers hold reset zeros until pin levels have crossed them;
   // flags stay quiet until then, so no false dropout follows reset
   logic [SYNC_STAGES-1:0] syncFill_r;
   wire                    syncFull = syncFill_r[SYNC_STAGES-1];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         syncFill_r <= '0;
      else
         syncFill_r <= {syncFill_r[SYNC_STAGES-2:0], 1'b1};
   end

   wire ovlIn      = syncB_r[PIN_OVERLOAD];
   wire settling   = syncB_r[PIN_SETTLING];
   wire loopFlow   = syncB_r[PIN_LOOP];
   wire offHook    = syncB_r[PIN_OFF_HOOK];
   wire lineSideEn = syncB_r[PIN_LINE_EN];
   wire oc160      = syncB_r[PIN_OC160];
   wire oc60       = syncB_r[PIN_OC60];

   // control registers
   logic [7:0]       rxGain_r;
   logic [7:0]       txGain_r;
   logic [CTL_W-1:0] lineCtl_r;
   logic [EV_W-1:0]  evStatus_r;
   logic [EV_W-1:0]  evMask_r;
   logic [2:0]       faultStatus_r;

   wire currentLimitSelect = lineCtl_r[CTL_CURRENT_LIMIT_SELECT];
   // billing tone enable is stored and read back, but never reaches the live flag

   // live flags
   wire rxOverloadLiveFlag  = ovlIn & ~settling;
   wire lineDropoutFlag     = ~loopFlow | (~offHook & lineSideEn);
   wire loopOvercurrentFlag = currentLimitSelect ? oc60 : oc160;
   wire [2:0] faultNxt;
   assign faultNxt[BIT_OVL_LIVE]    = syncFull & rxOverloadLiveFlag;
   assign faultNxt[BIT_DROPOUT]     = syncFull & lineDropoutFlag;
   assign faultNxt[BIT_OVERCURRENT] = syncFull & loopOvercurrentFlag;

   // previous flags for rising-edge events
   logic [2:0] faultPrev_r;

   // bus decode
   wire [7:0] wordIdx    = avs_address[ADDR_W-1:2];
   wire       hitStatus  = wordIdx == IDX_LINE_FAULT_STATUS;
   wire       hitRxGain  = wordIdx == IDX_MON_RX_GAIN;
   wire       hitTxGain  = wordIdx == IDX_MON_TX_GAIN;
   wire       hitEvent   = wordIdx == IDX_EVENT_STATUS;
   wire       hitMask    = wordIdx == IDX_EVENT_MASK;
   wire       hitCtl     = wordIdx == IDX_LINE_CONTROL;
   wire       lane0      = avs_byteenable[0];

   bus_state_t busState_r;
   bus_state_t busState_nxt;
   wire accept  = (busState_r == BUS_IDLE) && (avs_read || avs_write);
   wire answer  = (busState_r == BUS_ACK);
   // a write lands at the edge at which the master sees waitrequest low
   wire wrTake  = answer && avs_write && lane0;

   // one write strobe per writable register except event status, whose clears decode wrTake directly
   wire wrRxGain = wrTake && hitRxGain;
   wire wrTxGain = wrTake && hitTxGain;
   wire wrCtl    = wrTake && hitCtl;
   wire wrMask   = wrTake && hitMask;

   always_comb
   begin
      busState_nxt = busState_r;
      case (busState_r)
         BUS_IDLE:
            if (accept)
               busState_nxt = BUS_ACK;
         BUS_ACK:
            busState_nxt = BUS_IDLE;
         default:
            busState_nxt = BUS_IDLE;
      endcase
   end

   wire [7:0] wd = avs_writedata[7:0];

   wire [EV_W-1:0] evSet;
   assign evSet[EV_OVL_STICKY]  = faultNxt[BIT_OVL_LIVE];
   assign evSet[EV_DROPOUT]     = faultNxt[BIT_DROPOUT] & ~faultPrev_r[BIT_DROPOUT];
   assign evSet[EV_OVERCURRENT] = faultNxt[BIT_OVERCURRENT] & ~faultPrev_r[BIT_OVERCURRENT];

   // sticky overload bit cleared by writing 0 to it (also its interrupt flag);
   // other event bits clear by writing 1; a set in the same cycle wins
   wire [EV_W-1:0] evClr;
   assign evClr[EV_OVL_STICKY]  = wrTake && hitEvent && !wd[EV_OVL_STICKY];
   assign evClr[EV_DROPOUT]     = wrTake && hitEvent && wd[EV_DROPOUT];
   assign evClr[EV_OVERCURRENT] = wrTake && hitEvent && wd[EV_OVERCURRENT];
   wire [EV_W-1:0] evStatus_nxt = (evStatus_r & ~evClr) | evSet;

   wire [7:0] readMux =
      hitStatus ? {5'h00, faultStatus_r} :
      hitRxGain ? rxGain_r :
      hitTxGain ? txGain_r :
      hitEvent  ? {5'h00, evStatus_r} :
      hitMask   ? {5'h00, evMask_r} :
      hitCtl    ? {6'h00, lineCtl_r} : 8'h00;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         busState_r <= BUS_IDLE;
      else
         busState_r <= busState_nxt;
   end

   // waitrequest drops for the answer cycle only
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !accept;
   end

   // read data taken at the request, standing through the answer cycle
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (accept)
         avs_readdata <= {24'h00_0000, readMux};
   end

   // next values of the software registers
   wire [7:0]       rxGain_nxt  = wrRxGain ? wd : rxGain_r;
   wire [7:0]       txGain_nxt  = wrTxGain ? wd : txGain_r;
   wire [CTL_W-1:0] lineCtl_nxt = wrCtl ? wd[CTL_W-1:0] : lineCtl_r;
   wire [EV_W-1:0]  evMask_nxt  = wrMask ? wd[EV_W-1:0] : evMask_r;
   wire             irq_nxt     = |(evStatus_nxt & evMask_r);

   // software registers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rxGain_r <= RESET_BYTE;
      else
         rxGain_r <= rxGain_nxt;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         txGain_r <= RESET_BYTE;
      else
         txGain_r <= txGain_nxt;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         lineCtl_r <= '0;
      else
         lineCtl_r <= lineCtl_nxt;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         evMask_r <= '0;
      else
         evMask_r <= evMask_nxt;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         evStatus_r <= '0;
      else
         evStatus_r <= evStatus_nxt;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= irq_nxt;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         faultStatus_r <= 3'h0;
      else
         faultStatus_r <= faultNxt;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         faultPrev_r <= 3'h0;
      else
         faultPrev_r <= faultNxt;
   end

   monitor_gain_stage u_rx_gain
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .sampleIn  (rxSample),
      .gainCode  (rxGain_r),
      .sampleOut (monitorRxOut)
   );

   monitor_gain_stage u_tx_gain
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .sampleIn  (txSample),
      .gainCode  (txGain_r),
      .sampleOut (monitorTxOut)
   );

   // summed monitor signal, registered
   wire signed [SAMPLE_W:0] monitorSum_nxt = (SAMPLE_W+1)'(monitorRxOut)
                                           + (SAMPLE_W+1)'(monitorTxOut);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         monitorOutput <= '0;
      else
         monitorOutput <= monitorSum_nxt;
   end

endmodule // line_status_monitor_regs

/* src/line_mon_pkg.sv */
package line_mon_pkg;
   // register word indices; byte address is four times the index
   localparam logic [7:0] IDX_LINE_FAULT_STATUS = 8'h13;
   localparam logic [7:0] IDX_MON_RX_GAIN       = 8'h14;
   localparam logic [7:0] IDX_MON_TX_GAIN       = 8'h15;
   localparam logic [7:0] IDX_EVENT_STATUS      = 8'h16;
   localparam logic [7:0] IDX_EVENT_MASK        = 8'h17;
   localparam logic [7:0] IDX_LINE_CONTROL      = 8'h18;
   localparam int         ADDR_W                = 10;
   localparam logic [7:0] RESET_BYTE            = 8'h00;
   // line_fault_status field positions
   localparam int BIT_OVERCURRENT = 0;
   localparam int BIT_DROPOUT     = 1;
   localparam int BIT_OVL_LIVE    = 2;
   // event status / mask fields
   localparam int EV_OVL_STICKY   = 0;
   localparam int EV_DROPOUT      = 1;
   localparam int EV_OVERCURRENT  = 2;
   localparam int EV_W            = 3;
   // line control fields
   localparam int CTL_CURRENT_LIMIT_SELECT        = 0;
   localparam int CTL_BTE         = 1;
   localparam int CTL_W           = 2;
   // gain scaling: unity code is 64, so gain = code / 64
   localparam int GAIN_SHIFT      = 6;
   localparam int SAMPLE_W        = 16;
   localparam int PRODUCT_W       = 24;
   localparam logic [7:0] GAIN_MUTE = 8'h00;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_t;
endpackage

/* src/monitor_gain_stage.sv */
`timescale 1ns/10ps
module monitor_gain_stage
   import line_mon_pkg::*;
(
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic signed [SAMPLE_W-1:0] sampleIn,
   input  wire logic        [7:0]          gainCode,
   output logic signed      [SAMPLE_W-1:0] sampleOut
);
   logic signed [PRODUCT_W-1:0] product;
   logic signed [PRODUCT_W-1:0] scaled;
   logic signed [SAMPLE_W-1:0]  sat;
   localparam logic signed [PRODUCT_W-1:0] MAXV = PRODUCT_W'(2**(SAMPLE_W-1)-1);
   localparam logic signed [PRODUCT_W-1:0] MINV = -PRODUCT_W'(2**(SAMPLE_W-1));

   // linear gain code/64; code zero gives exactly zero (mute)
   assign product = PRODUCT_W'(sampleIn) * $signed({1'b0, gainCode});
   assign scaled  = product >>> GAIN_SHIFT;
   assign sat     = (scaled > MAXV) ? MAXV[SAMPLE_W-1:0] :
                    (scaled < MINV) ? MINV[SAMPLE_W-1:0] : scaled[SAMPLE_W-1:0];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         sampleOut <= '0;
      else if (gainCode == GAIN_MUTE)
         sampleOut <= '0;
      else
         sampleOut <= sat;
   end
endmodule // monitor_gain_stage

/* bench/line_status_monitor_regs_sva.sv */
`timescale 1ns/10ps
module line_status_monitor_regs_chk
   import line_mon_pkg::*;
(
   input wire logic                       clk_sys,
   input wire logic                       rst_n,
   input wire logic [ADDR_W-1:0]          avs_address,
   input wire logic                       avs_read,
   input wire logic                       avs_write,
   input wire logic [31:0]                avs_writedata,
   input wire logic [3:0]                 avs_byteenable,
   input wire logic [31:0]                avs_readdata,
   input wire logic                       avs_waitrequest,
   input wire logic signed [SAMPLE_W-1:0] rxSample,
   input wire logic signed [SAMPLE_W-1:0] txSample,
   input wire logic signed [SAMPLE_W-1:0] monitorRxOut,
   input wire logic signed [SAMPLE_W-1:0] monitorTxOut,
   input wire logic                       irq
);
   logic [7:0] rxGain_r;
   logic [7:0] txGain_r;
   wire        gainWr = avs_write && !avs_waitrequest && avs_byteenable[0];
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         {rxGain_r, txGain_r} <= 16'h0000;
      else if (gainWr && avs_address[9:2] == IDX_MON_RX_GAIN)
         rxGain_r <= avs_writedata[7:0];
      else if (gainWr && avs_address[9:2] == IDX_MON_TX_GAIN)
         txGain_r <= avs_writedata[7:0];
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence taken_s; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence answer_s; !avs_waitrequest ##1 avs_waitrequest; endsequence
   take_answer_a: assert property (taken_s |=> answer_s) else $error("bus answer wrong");
   idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
      else $error("answer without request");
   read_upper_a: assert property (avs_readdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   sequence status_read_s;
      avs_read && avs_waitrequest && avs_address[9:2] == IDX_LINE_FAULT_STATUS;
   endsequence
   status_upper_a: assert property (status_read_s |=> avs_readdata[7:3] == 5'h00)
      else $error("unused status bits set");
   reset_quiet_a: assert property ($rose(rst_n) |-> !irq && monitorRxOut == 16'sh0000)
      else $error("outputs not quiet after reset");
   rx_mute_a: assert property ((rxGain_r == 8'h00)[*3] |-> monitorRxOut == 16'sh0000)
      else $error("rx path not muted");
   tx_mute_a: assert property ((txGain_r == 8'h00)[*3] |-> monitorTxOut == 16'sh0000)
      else $error("tx path not muted");
   rx_unity_a: assert property ((rxGain_r == 8'h40)[*3] |-> monitorRxOut == $past(rxSample))
      else $error("rx unity gain wrong");
   tx_unity_a: assert property ((txGain_r == 8'h40)[*3] |-> monitorTxOut == $past(txSample))
      else $error("tx unity gain wrong");
endmodule // line_status_monitor_regs_chk
bind line_status_monitor_regs line_status_monitor_regs_chk chk (.clk_sys(clk_sys), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .rxSample(rxSample), .txSample(txSample),
   .monitorRxOut(monitorRxOut), .monitorTxOut(monitorTxOut), .irq(irq));

/* bench/line_status_monitor_regs_tb.sv */
`timescale 1ns/10ps
module line_status_monitor_regs_tb
   import line_mon_pkg::*;
();
   logic                       clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, irq;
   logic [ADDR_W-1:0]          avs_address;
   logic [31:0]                avs_writedata, avs_readdata, rd;
   logic [3:0]                 avs_byteenable;
   logic [6:0]                 pins;
   logic [7:0]                 gr, gt;
   logic [15:0]                lfsr;
   logic signed [SAMPLE_W-1:0] rxSample, txSample, monitorRxOut, monitorTxOut;
   logic signed [SAMPLE_W:0]   monitorOutput;
   logic [7:0]                 corner [6] = '{8'h00, 8'h40, 8'hff, 8'h7f, 8'h20, 8'h10};
   int                         n_errors, num_checks, cycles;
   line_status_monitor_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rxOverloadPin(pins[6]), .offHookSettlingPin(pins[5]),
      .loopCurrentPin(pins[4]), .offHookPin(pins[3]), .lineSideEnablePin(pins[2]),
      .overcurrent160Pin(pins[1]), .overcurrent60Pin(pins[0]), .rxSample(rxSample),
      .txSample(txSample), .monitorRxOut(monitorRxOut), .monitorTxOut(monitorTxOut),
      .monitorOutput(monitorOutput), .irq(irq));
   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic signed [15:0] gexp(input logic signed [15:0] s, input logic [7:0] c);
      logic signed [24:0] p;
      p = (s * $signed({1'b0, c})) >>> 6;
      return (p > 25'sd32767) ? 16'sh7fff : (p < -25'sd32768) ? 16'sh8000 : p[15:0];
   endfunction
   // status from {bte, current_limit_select, pins}
   function automatic logic [7:0] sexp(input logic [8:0] v);
      return {5'h00, v[6] & ~v[5], ~v[4] | (~v[3] & v[2]), v[7] ? v[0] : v[1]};
   endfunction
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h000000, d};
      {avs_write, avs_read} <= {wr, !wr};
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk_sys);
      rd = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check(rd, {24'h000000, exp});
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         end_sim();
      end
   end
   initial
   begin
      rst_n = 1'b0;
      {avs_read, avs_write, pins, avs_address, avs_writedata} = {9'h018, 42'h0};
      {avs_byteenable, rxSample, txSample, lfsr} = {4'h1, 32'h0, 16'h000d};
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd_chk(IDX_LINE_FAULT_STATUS, 8'h00);
      rd_chk(IDX_MON_RX_GAIN, 8'h00);
      rd_chk(IDX_MON_TX_GAIN, 8'h00);
      rd_chk(8'h30, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 14; i++)
      begin
         lfsr = lfsr_step(lfsr);
         gr = (i < 6) ? corner[i] : lfsr[7:0];
         gt = (i < 6) ? corner[5 - i] : lfsr[15:8];
         bus(1'b1, IDX_MON_RX_GAIN, gr);
         bus(1'b1, IDX_MON_TX_GAIN, gt);
         lfsr = lfsr_step(lfsr);
         {rxSample, txSample} <= {lfsr, ~lfsr};
         repeat (4) @(posedge clk_sys);
         check(monitorRxOut, gexp(lfsr, gr));
         check(monitorTxOut, gexp(~lfsr, gt));
         check(monitorOutput, gexp(lfsr, gr) + gexp(~lfsr, gt));
      end
      avs_byteenable <= 4'h0;
      bus(1'b1, IDX_MON_RX_GAIN, 8'h5a);
      avs_byteenable <= 4'h1;
      rd_chk(IDX_MON_RX_GAIN, gr);
      rd_chk(IDX_MON_TX_GAIN, gt);
      $display("gain test done");
      for (int i = 0; i < 24; i++)
      begin
         lfsr = lfsr_step(lfsr);
         bus(1'b1, IDX_LINE_CONTROL, {6'h00, lfsr[8:7]});
         pins <= lfsr[6:0];
         repeat (4) @(posedge clk_sys);
         bus(1'b1, IDX_LINE_FAULT_STATUS, ~sexp(lfsr[8:0]));
         rd_chk(IDX_LINE_FAULT_STATUS, sexp(lfsr[8:0]));
      end
      $display("status test done");
      pins <= 7'h18;
      bus(1'b1, IDX_EVENT_MASK, 8'h01);
      bus(1'b1, IDX_EVENT_STATUS, 8'h06);
      rd_chk(IDX_EVENT_STATUS, 8'h00);
      check(irq, 1'b0);
      pins <= 7'h58;
      repeat (4) @(posedge clk_sys);
      pins <= 7'h18;
      repeat (4) @(posedge clk_sys);
      rd_chk(IDX_LINE_FAULT_STATUS, 8'h00);
      rd_chk(IDX_EVENT_STATUS, 8'h01);
      check(irq, 1'b1);
      bus(1'b1, IDX_EVENT_MASK, 8'h00);
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b0);
      bus(1'b1, IDX_EVENT_STATUS, 8'h01);
      rd_chk(IDX_EVENT_STATUS, 8'h01);
      bus(1'b1, IDX_EVENT_STATUS, 8'h00);
      rd_chk(IDX_EVENT_STATUS, 8'h00);
      $display("event test done");
      end_sim();
   end
endmodule // line_status_monitor_regs_tb
